// >>> spab_top.sv
// s/pdif autobuffer, interrupt status and shared pin select
// Functional notes
// RL1: received status and user bits reach the transmitter with no host access.
// RL2: separate enables for channel status and user bit copying.
// RL3: equal rates give transmitted bits identical to received bits.
// RL4: faster transmitter sends a received block a second time.
// RL5: slower transmitter may discard received blocks.
// RL6: host decides on professional streams with address or time bytes.
// RL7: zero adjust with faster transmitter adds zeros between messages.
// RL8: zero adjust with slower transmitter removes zeros between messages.
// RL9: when message gaps run short, zeros between units are removed too.
// RL10: zero insertion and removal only while zero adjust enable is set.
// RL11: status bits stay set until the status register is read.
// RL12: summary flags for rate converter and receiver faults.
// RL13: each status bit has a mask; only masked-in bits interrupt.
// RL14: pin shows left silence when select is 0, interrupt when 1.
// RL15: eight or more zeros between units end a message.
// RL16: interrupt pin high while any status and mask bit pair is one.
// RL17: an event in the cycle of a status read keeps its bit set.
`timescale 1ns/1ps
module spab_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire logic [spab_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spab_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [spab_pkg::DATA_W-1:0] reg_rdata,
	// receiver buffers
	input wire logic rx_frame,
	input wire logic rx_blk_start,
	input wire logic rx_cs_bit,
	input wire logic rx_ub_bit,
	// transmitter buffers
	input wire logic tx_frame,
	input wire logic tx_blk_start,
	output logic tx_bit_valid,
	output logic tx_cs_bit,
	output logic tx_ub_bit,
	output logic tx_cs_auto,
	output logic tx_ub_auto,
	// fault events and silence flag
	input wire logic rate_conv_fault_evt,
	input wire logic receiver_fault_evt,
	input wire logic left_silence,
	// shared pin
	output logic left_silence_or_irq_pin
);
	// register state
	logic [spab_pkg::CTL_W-1:0] ctrl_r, ctrl_nxt;
	logic [spab_pkg::STAT_W-1:0] mask_r, mask_nxt;
	logic [spab_pkg::STAT_W-1:0] stat_r, stat_nxt;
	logic [spab_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic pin_r, pin_nxt;
	logic [spab_pkg::STAT_W-1:0] evt;
	// zero adjust state
	logic [2:0] rx_rem_r, rx_rem_nxt, tx_rem_r, tx_rem_nxt;
	logic [3:0] rx_run_r, rx_run_nxt, tx_run_r, tx_run_nxt;
	logic zmode, in_gap, msg_gap, drop_zero, insert_zero;
	logic f_push, f_pop, f_full, f_empty, f_head, z_bit;
	logic [spab_pkg::FIFO_AW:0] f_level;
	// transmit output state
	logic tx_val_r, tx_val_nxt, tx_cs_r, tx_cs_nxt, tx_ub_r, tx_ub_nxt;
	logic blk_cs, blk_ub, blk_rep, blk_drop;
	logic autocopy_chanstat_en, autocopy_userbit_en;
	logic zero_adjust_en, shared_pin_function_sel;

	// unit tracking: remaining bits of a unit, zero run between units
	function automatic logic [6:0] iu_step(input logic [2:0] rem,
			input logic [3:0] run, input logic bit_in);
		logic [2:0] r;
		logic [3:0] z;
		r = rem;
		z = run;
		if (rem != 3'h0) begin
			r = rem - 3'h1;
			z = 4'h0;
		end else if (bit_in) begin
			r = spab_pkg::IU_TAIL;
			z = 4'h0;
		end else if (run != 4'hf) begin
			z = run + 4'h1;
		end
		iu_step = {r, z};
	endfunction

	spab_rx_if rxs ();
	assign rxs.frame = rx_frame;
	assign rxs.blk_start = rx_blk_start;
	assign rxs.cs = rx_cs_bit;
	assign rxs.ub = rx_ub_bit;

	// block copy path, repeat and drop for rate mismatch
	spab_blkcopy #(
		.BITS(spab_pkg::BLK_BITS)
	) u_blk (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.rx(rxs),
		.tx_frame(tx_frame),
		.tx_blk_start(tx_blk_start),
		.cs_bit(blk_cs),
		.ub_bit(blk_ub),
		.repeat_evt(blk_rep),
		.drop_evt(blk_drop)
	);

	spab_ubfifo #(
		.DEPTH(spab_pkg::FIFO_DEPTH),
		.AW(spab_pkg::FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.push(f_push),
		.wdata(rx_ub_bit),
		.full(f_full),
		.pop(f_pop),
		.rdata(f_head),
		.empty(f_empty),
		.level(f_level)
	);

	always_comb begin
		autocopy_chanstat_en = ctrl_r[spab_pkg::CTL_CS];
		autocopy_userbit_en = ctrl_r[spab_pkg::CTL_UB];
		zero_adjust_en = ctrl_r[spab_pkg::CTL_ZADJ];
		shared_pin_function_sel = ctrl_r[spab_pkg::CTL_PINSEL];
	end

	// zero adjust: elastic user bit path
	always_comb begin
		zmode = autocopy_userbit_en && zero_adjust_en; // RL10
		in_gap = (rx_rem_r == 3'h0) && !rx_ub_bit;
		msg_gap = (rx_run_r >= spab_pkg::MSG_GAP_RUN); // RL15
		drop_zero = in_gap && ((msg_gap && f_level >= spab_pkg::HI_WM) // RL8
			|| f_level >= spab_pkg::FULL_WM); // RL9
		f_push = zmode && rx_frame && !drop_zero && !f_full;
		{rx_rem_nxt, rx_run_nxt} = {rx_rem_r, rx_run_r};
		if (zmode && rx_frame) begin
			{rx_rem_nxt, rx_run_nxt} = iu_step(rx_rem_r, rx_run_r, rx_ub_bit);
		end
		insert_zero = (tx_rem_r == 3'h0) && (f_empty
			|| (tx_run_r >= spab_pkg::MSG_GAP_RUN
			&& f_level < spab_pkg::LO_WM)); // RL7
		f_pop = zmode && tx_frame && !insert_zero && !f_empty;
		z_bit = f_pop ? f_head : 1'b0;
		{tx_rem_nxt, tx_run_nxt} = {tx_rem_r, tx_run_r};
		if (zmode && tx_frame) begin
			{tx_rem_nxt, tx_run_nxt} = iu_step(tx_rem_r, tx_run_r, z_bit);
		end
		if (!zmode) begin
			{rx_rem_nxt, rx_run_nxt} = 7'h00;
			{tx_rem_nxt, tx_run_nxt} = 7'h00;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_rem_r <= 3'h0;
			rx_run_r <= 4'h0;
			tx_rem_r <= 3'h0;
			tx_run_r <= 4'h0;
		end else begin
			rx_rem_r <= rx_rem_nxt;
			rx_run_r <= rx_run_nxt;
			tx_rem_r <= tx_rem_nxt;
			tx_run_r <= tx_run_nxt;
		end
	end

	// transmitter bit outputs
	always_comb begin
		tx_val_nxt = tx_frame;
		tx_cs_nxt = tx_cs_r;
		tx_ub_nxt = tx_ub_r;
		if (tx_frame) begin
			tx_cs_nxt = autocopy_chanstat_en ? blk_cs : 1'b0; // RL1 RL2
			if (!autocopy_userbit_en) begin
				tx_ub_nxt = 1'b0; // RL2
			end else if (zmode) begin
				tx_ub_nxt = z_bit;
			end else begin
				tx_ub_nxt = blk_ub; // RL1
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_val_r <= 1'b0;
			tx_cs_r <= 1'b0;
			tx_ub_r <= 1'b0;
		end else begin
			tx_val_r <= tx_val_nxt;
			tx_cs_r <= tx_cs_nxt;
			tx_ub_r <= tx_ub_nxt;
		end
	end

	// registers, sticky status, interrupt pin
	always_comb begin
		evt = '0;
		evt[spab_pkg::ST_RATE_CONV] = rate_conv_fault_evt; // RL12
		evt[spab_pkg::ST_RECEIVER] = receiver_fault_evt; // RL12
		evt[spab_pkg::ST_REPEAT] = blk_rep
			&& (autocopy_chanstat_en || (autocopy_userbit_en && !zmode));
		evt[spab_pkg::ST_DROP] = blk_drop
			&& (autocopy_chanstat_en || (autocopy_userbit_en && !zmode));
		evt[spab_pkg::ST_OVERFLOW] = zmode && rx_frame && !drop_zero && f_full;
		evt[spab_pkg::ST_UNDERRUN] = zmode && tx_frame && f_empty
			&& (tx_rem_r != 3'h0);
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		if (reg_wr && reg_addr == spab_pkg::OFS_CTRL) begin
			ctrl_nxt = reg_wdata[spab_pkg::CTL_W-1:0];
		end
		if (reg_wr && reg_addr == spab_pkg::OFS_MASK) begin
			mask_nxt = reg_wdata[spab_pkg::STAT_W-1:0];
		end
		stat_nxt = stat_r;
		if (reg_rd && reg_addr == spab_pkg::OFS_STAT) begin
			stat_nxt = '0; // RL11
		end
		stat_nxt = stat_nxt | evt; // RL11 RL17
		rdata_nxt = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				spab_pkg::OFS_CTRL: rdata_nxt = pad_ctrl(ctrl_r);
				spab_pkg::OFS_MASK: rdata_nxt = pad_stat(mask_r);
				spab_pkg::OFS_STAT: rdata_nxt = pad_stat(stat_r);
				spab_pkg::OFS_LEVEL: rdata_nxt = {1'b0, f_level};
				default: rdata_nxt = '0;
			endcase
		end
		if (shared_pin_function_sel) begin
			pin_nxt = |(stat_r & mask_r); // RL13 RL14 RL16
		end else begin
			pin_nxt = left_silence; // RL14
		end
	end

	function automatic logic [7:0] pad_ctrl(input logic [3:0] v);
		pad_ctrl = {4'h0, v};
	endfunction

	function automatic logic [7:0] pad_stat(input logic [5:0] v);
		pad_stat = {2'h0, v};
	endfunction

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= spab_pkg::CTRL_RST;
			mask_r <= spab_pkg::MASK_RST;
			stat_r <= spab_pkg::STAT_RST;
			rdata_r <= '0;
			pin_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			rdata_r <= rdata_nxt;
			pin_r <= pin_nxt;
		end
	end

	always_comb begin
		reg_rdata = rdata_r;
		tx_bit_valid = tx_val_r;
		tx_cs_bit = tx_cs_r;
		tx_ub_bit = tx_ub_r;
		tx_cs_auto = ctrl_r[spab_pkg::CTL_CS];
		tx_ub_auto = ctrl_r[spab_pkg::CTL_UB];
		left_silence_or_irq_pin = pin_r;
	end
endmodule

// >>> spab_pkg.sv
// constants for the s/pdif autobuffer and interrupt status block
package spab_pkg;
	// block geometry
	localparam int BLK_BITS = 192;
	localparam int IDX_W = 8;
	// register offsets
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_LEVEL = 8'h0c;
	// control fields
	localparam int CTL_W = 4;
	localparam int CTL_CS = 0;
	localparam int CTL_UB = 1;
	localparam int CTL_ZADJ = 2;
	localparam int CTL_PINSEL = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// status and mask fields
	localparam int STAT_W = 6;
	localparam int ST_RATE_CONV = 0;
	localparam int ST_RECEIVER = 1;
	localparam int ST_REPEAT = 2;
	localparam int ST_DROP = 3;
	localparam int ST_OVERFLOW = 4;
	localparam int ST_UNDERRUN = 5;
	localparam logic [5:0] MASK_RST = 6'h00;
	localparam logic [5:0] STAT_RST = 6'h00;
	// user data framing
	localparam logic [3:0] MSG_GAP_RUN = 4'h8;
	localparam logic [2:0] IU_TAIL = 3'h7;
	// user bit elastic store
	localparam int FIFO_DEPTH = 64;
	localparam int FIFO_AW = 6;
	localparam logic [6:0] LO_WM = 7'h18;
	localparam logic [6:0] HI_WM = 7'h28;
	localparam logic [6:0] FULL_WM = 7'h38;
endpackage

// >>> spab_rx_if.sv
// received channel status and user bit stream between modules
`timescale 1ns/1ps
interface spab_rx_if;
	logic frame;
	logic blk_start;
	logic cs;
	logic ub;
	modport src (output frame, output blk_start, output cs, output ub);
	modport snk (input frame, input blk_start, input cs, input ub);
endinterface

// >>> spab_blkcopy.sv
// block copy of channel status and user bits with repeat and drop
`timescale 1ns/1ps
module spab_blkcopy #(
	parameter int BITS = spab_pkg::BLK_BITS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// received stream
	spab_rx_if.snk rx,
	// transmitter side
	input wire logic tx_frame,
	input wire logic tx_blk_start,
	output logic cs_bit,
	output logic ub_bit,
	output logic repeat_evt,
	output logic drop_evt
);
	logic [BITS-1:0] fill_cs_r, fill_cs_nxt, fill_ub_r, fill_ub_nxt;
	logic [BITS-1:0] hold_cs_r, hold_cs_nxt, hold_ub_r, hold_ub_nxt;
	logic [BITS-1:0] out_cs_r, out_cs_nxt, out_ub_r, out_ub_nxt;
	logic [spab_pkg::IDX_W-1:0] fill_idx_r, fill_idx_nxt;
	logic [spab_pkg::IDX_W-1:0] out_idx_r, out_idx_nxt;
	logic hold_new_r, hold_new_nxt, loaded_r, loaded_nxt;
	logic [spab_pkg::IDX_W-1:0] widx;
	logic commit, take;

	always_comb begin
		fill_cs_nxt = fill_cs_r;
		fill_ub_nxt = fill_ub_r;
		fill_idx_nxt = fill_idx_r;
		hold_cs_nxt = hold_cs_r;
		hold_ub_nxt = hold_ub_r;
		out_cs_nxt = out_cs_r;
		out_ub_nxt = out_ub_r;
		out_idx_nxt = out_idx_r;
		hold_new_nxt = hold_new_r;
		loaded_nxt = loaded_r;
		repeat_evt = 1'b0;
		drop_evt = 1'b0;
		commit = 1'b0;
		widx = rx.blk_start ? '0 : fill_idx_r;
		// receiver side fills a block, aligned to the block start
		if (rx.frame && widx < spab_pkg::IDX_W'(BITS)) begin
			fill_cs_nxt[widx] = rx.cs;
			fill_ub_nxt[widx] = rx.ub;
			fill_idx_nxt = widx + 1'b1;
			commit = (widx == spab_pkg::IDX_W'(BITS - 1));
		end
		// transmitter takes the newest whole block at its block start
		take = tx_frame && tx_blk_start;
		if (take) begin
			out_idx_nxt = 8'h01;
			if (hold_new_r) begin
				out_cs_nxt = hold_cs_r;
				out_ub_nxt = hold_ub_r;
				hold_new_nxt = 1'b0;
				loaded_nxt = 1'b1;
			end else if (loaded_r) begin
				repeat_evt = 1'b1; // RL4
			end
		end else if (tx_frame && out_idx_r < spab_pkg::IDX_W'(BITS)) begin
			out_idx_nxt = out_idx_r + 1'b1;
		end
		if (commit) begin
			hold_cs_nxt = fill_cs_nxt;
			hold_ub_nxt = fill_ub_nxt;
			hold_new_nxt = 1'b1;
			drop_evt = hold_new_r && !take; // RL5
		end
		// first bit of a freshly taken block comes straight from hold
		if (take && hold_new_r) begin
			cs_bit = hold_cs_r[0]; // RL3
			ub_bit = hold_ub_r[0];
		end else if (take) begin
			cs_bit = out_cs_r[0];
			ub_bit = out_ub_r[0];
		end else if (out_idx_r < spab_pkg::IDX_W'(BITS)) begin
			cs_bit = out_cs_r[out_idx_r];
			ub_bit = out_ub_r[out_idx_r];
		end else begin
			// past the block end: no stale index into the store
			cs_bit = 1'b0;
			ub_bit = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fill_cs_r <= '0;
			fill_ub_r <= '0;
			hold_cs_r <= '0;
			hold_ub_r <= '0;
			out_cs_r <= '0;
			out_ub_r <= '0;
			fill_idx_r <= '0;
			out_idx_r <= '0;
			hold_new_r <= 1'b0;
			loaded_r <= 1'b0;
		end else begin
			fill_cs_r <= fill_cs_nxt;
			fill_ub_r <= fill_ub_nxt;
			hold_cs_r <= hold_cs_nxt;
			hold_ub_r <= hold_ub_nxt;
			out_cs_r <= out_cs_nxt;
			out_ub_r <= out_ub_nxt;
			fill_idx_r <= fill_idx_nxt;
			out_idx_r <= out_idx_nxt;
			hold_new_r <= hold_new_nxt;
			loaded_r <= loaded_nxt;
		end
	end
endmodule

// >>> spab_ubfifo.sv
// elastic store for user bits in zero adjust mode
`timescale 1ns/1ps
module spab_ubfifo #(
	parameter int DEPTH = spab_pkg::FIFO_DEPTH,
	parameter int AW = spab_pkg::FIFO_AW
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// fill side
	input wire logic push,
	input wire logic wdata,
	output logic full,
	// drain side
	input wire logic pop,
	output logic rdata,
	output logic empty,
	output logic [AW:0] level
);
	logic [DEPTH-1:0] mem_r, mem_nxt;
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] lvl_r, lvl_nxt;
	logic do_push, do_pop;

	always_comb begin
		full = (lvl_r == (AW+1)'(DEPTH));
		empty = (lvl_r == '0);
		level = lvl_r;
		rdata = mem_r[rp_r];
		do_push = push && !full;
		do_pop = pop && !empty;
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (do_push) begin
			mem_nxt[wp_r] = wdata;
			wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
		end
		if (do_pop) begin
			rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
		end
		lvl_nxt = lvl_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_r <= '0;
			wp_r <= '0;
			rp_r <= '0;
			lvl_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			lvl_r <= lvl_nxt;
		end
	end
endmodule

// >>> spab_assertions.sv
// concurrent checks on the autobuffer and interrupt block ports
`timescale 1ns/1ps
module spab_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire logic [spab_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spab_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [spab_pkg::DATA_W-1:0] reg_rdata,
	// transmitter side
	input wire logic tx_frame,
	input wire logic tx_bit_valid,
	input wire logic tx_cs_bit,
	input wire logic tx_ub_bit,
	input wire logic tx_cs_auto,
	input wire logic tx_ub_auto,
	// events and pin
	input wire logic rate_conv_fault_evt,
	input wire logic receiver_fault_evt,
	input wire logic left_silence,
	input wire logic left_silence_or_irq_pin
);
	logic [3:0] ctrl_r, ctrl_nxt;
	logic [5:0] mask_r, mask_nxt;
	logic [1:0] flt_r, flt_nxt;
	logic stat_rd;
	// shadow of control, mask and the two fault status bits
	always_comb begin
		stat_rd = reg_rd && reg_addr == spab_pkg::OFS_STAT;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		if (reg_wr && reg_addr == spab_pkg::OFS_CTRL)
			ctrl_nxt = reg_wdata[3:0];
		if (reg_wr && reg_addr == spab_pkg::OFS_MASK)
			mask_nxt = reg_wdata[5:0];
		flt_nxt = {receiver_fault_evt, rate_conv_fault_evt};
		flt_nxt = flt_nxt | (stat_rd ? 2'b00 : flt_r);
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= 4'h0;
			mask_r <= 6'h00;
			flt_r <= 2'b00;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			flt_r <= flt_nxt;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence stat_read;
		reg_rd && reg_addr == spab_pkg::OFS_STAT;
	endsequence
	sequence ctrl_read;
		reg_rd && reg_addr == spab_pkg::OFS_CTRL;
	endsequence
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
	AST_CTRL_RB: assert property (
		ctrl_read |=> reg_rdata == {4'h0, $past(ctrl_r)})
		else $error("control readback wrong");
	AST_MASK_RB: assert property (
		reg_rd && reg_addr == spab_pkg::OFS_MASK |=>
		reg_rdata == {2'h0, $past(mask_r)}) else $error("mask readback wrong");
	AST_STAT_RB: assert property (
		stat_read |=> reg_rdata[1:0] == $past(flt_r))
		else $error("fault status bits wrong");
	AST_UNMAPPED: assert property (
		reg_rd && !(reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	AST_IRQ_ON: assert property (
		ctrl_r[3] && (flt_r & mask_r[1:0]) != 2'b00 |=>
		left_silence_or_irq_pin) else $error("interrupt pin missing");
	AST_IRQ_OFF: assert property (
		ctrl_r[3] && mask_r == 6'h00 |=> !left_silence_or_irq_pin)
		else $error("masked interrupt on pin");
	AST_PIN_SIL: assert property (
		!ctrl_r[3] |=> left_silence_or_irq_pin == $past(left_silence))
		else $error("pin not showing silence flag");
	AST_TX_VALID: assert property (
		tx_frame |=> tx_bit_valid ##1 (tx_bit_valid == $past(tx_frame)))
		else $error("tx valid timing wrong");
	AST_AUTO: assert property (
		{tx_ub_auto, tx_cs_auto} == ctrl_r[1:0]) else $error("auto flags");
	AST_TX_OFF: assert property (
		tx_frame && ctrl_r[1:0] == 2'b00 |=> !tx_cs_bit && !tx_ub_bit)
		else $error("tx bits sent with copy off");
endmodule

// >>> testbench.sv
// self-checking bench for the autobuffer and interrupt block
`timescale 1ns/1ps
module testbench;
	logic core_clk, reset_n, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, m_stat;
	logic rx_frame, rx_blk_start, rx_cs_bit, rx_ub_bit;
	logic tx_frame, tx_blk_start, tx_bit_valid, tx_cs_bit, tx_ub_bit;
	logic tx_cs_auto, tx_ub_auto, left_silence, left_silence_or_irq_pin;
	logic rate_conv_fault_evt, receiver_fault_evt;
	logic [191:0] m_cs, m_ub, n_cs, n_ub;
	logic [31:0] seed, r;
	int bad_count, check_count, fresh, got_one;
	logic [7:0] uq[$];
	logic zq[$];
	spab_top DUT (.*);
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string n, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// read with an optional fault event in the same cycle
	task automatic rd(input logic [7:0] a, e, input logic ev);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rate_conv_fault_evt <= ev;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		rate_conv_fault_evt <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
		@(posedge core_clk);
	endtask
	task automatic evt(input logic rx);
		rate_conv_fault_evt <= !rx;
		receiver_fault_evt <= rx;
		@(posedge core_clk);
		rate_conv_fault_evt <= 1'b0;
		receiver_fault_evt <= 1'b0;
	endtask
	task automatic pin_is(input logic e);
		repeat (2) @(posedge core_clk);
		#1 chk("pin", {7'h0, e}, {7'h0, left_silence_or_irq_pin});
	endtask
	task automatic rx_blk();
		for (int i = 0; i < 192; i++) begin
			r = xs();
			rx_frame <= 1'b1;
			rx_blk_start <= (i == 0);
			rx_cs_bit <= r[0];
			rx_ub_bit <= r[1];
			n_cs[i] = r[0];
			n_ub[i] = r[1];
			@(posedge core_clk);
			rx_frame <= 1'b0;
			@(posedge core_clk);
		end
		if (fresh != 0)
			m_stat[3] = 1'b1;
		m_cs = n_cs;
		m_ub = n_ub;
		fresh = 1;
		got_one = 1;
	endtask
	task automatic tx_blk();
		if (fresh == 0 && got_one != 0)
			m_stat[2] = 1'b1;
		fresh = 0;
		for (int i = 0; i < 192; i++) begin
			tx_frame <= 1'b1;
			tx_blk_start <= (i == 0);
			@(posedge core_clk);
			tx_frame <= 1'b0;
			#1 chk("tx", {5'h1, m_cs[i], m_ub[i]},
				{5'h0, tx_bit_valid, tx_cs_bit, tx_ub_bit});
			@(posedge core_clk);
		end
	endtask
	// zero adjust run: rx in ra, tx in ta of every 8 cycles; units compared
	task automatic zadj(input int ra, ta);
		int cnt, lim;
		logic [7:0] u;
		logic b;
		cnt = 0;
		u = 8'h00;
		for (int m = 0; m < 6; m++) begin
			repeat (12) zq.push_back(1'b0);
			for (int k = 0; k < 3; k++) begin
				r = xs();
				uq.push_back({1'b1, r[6:0]});
				for (int j = 7; j >= 0; j--)
					zq.push_back(j == 7 ? 1'b1 : r[j]);
				if (k < 2)
					repeat (2) zq.push_back(1'b0);
			end
		end
		for (lim = 0; lim < 4000 && uq.size() > 0; lim++) begin
			b = 1'b0;
			if (lim % 8 < ra && zq.size() > 0)
				b = zq.pop_front();
			rx_frame <= (lim % 8 < ra);
			rx_ub_bit <= b;
			tx_frame <= (lim % 8 < ta);
			@(negedge core_clk);
			if (tx_bit_valid) begin
				chk("zcs", 8'h00, {7'h0, tx_cs_bit});
				if (cnt == 0 && tx_ub_bit) begin
					u = 8'h01;
					cnt = 7;
				end else if (cnt != 0) begin
					u = {u[6:0], tx_ub_bit};
					cnt--;
					if (cnt == 0)
						chk("unit", uq.pop_front(), u);
				end
			end
			@(posedge core_clk);
		end
		rx_frame <= 1'b0;
		tx_frame <= 1'b0;
		zq.delete();
		chk("units left", 8'h00, 8'(uq.size()));
		if (uq.size() != 0)
			report_and_stop();
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{rx_frame, rx_blk_start, rx_cs_bit, rx_ub_bit} = '0;
		{tx_frame, tx_blk_start, left_silence} = '0;
		{rate_conv_fault_evt, receiver_fault_evt} = '0;
		{m_cs, m_ub, m_stat, fresh, got_one} = '0;
		seed = 32'd52393;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd(8'(i * 4), 8'h00, 1'b0);
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00, 1'b0);
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h0f, 1'b0);
		for (int i = 0; i < 4; i++) begin
			r = xs();
			wr(8'h04, r[7:0]);
			rd(8'h04, r[7:0] & 8'h3f, 1'b0);
		end
		$display("test registers done");
		wr(8'h00, 8'h08);
		wr(8'h04, 8'h01);
		evt(1'b1);
		pin_is(1'b0);
		evt(1'b0);
		pin_is(1'b1);
		rd(8'h08, 8'h03, 1'b1);
		rd(8'h08, 8'h01, 1'b0);
		pin_is(1'b0);
		rd(8'h08, 8'h00, 1'b0);
		wr(8'h00, 8'h00);
		left_silence <= 1'b1;
		pin_is(1'b1);
		left_silence <= 1'b0;
		pin_is(1'b0);
		$display("test interrupts done");
		tx_blk();
		wr(8'h00, 8'h03);
		chk("auto", 8'h03, {6'h0, tx_ub_auto, tx_cs_auto});
		rx_blk();
		tx_blk();
		tx_blk();
		rx_blk();
		rx_blk();
		tx_blk();
		rd(8'h08, m_stat, 1'b0);
		$display("test block copy done");
		wr(8'h00, 8'h06);
		zadj(8, 8);
		zadj(7, 8);
		zadj(8, 7);
		rd(8'h08, 8'h00, 1'b0);
		$display("test zero adjust done");
		report_and_stop();
	end
endmodule
bind spab_top spab_assertions u_chk (.core_clk, .reset_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_frame, .tx_bit_valid,
	.tx_cs_bit, .tx_ub_bit, .tx_cs_auto, .tx_ub_auto, .rate_conv_fault_evt,
	.receiver_fault_evt, .left_silence, .left_silence_or_irq_pin);
